// ==== hdl/mac_status_defines.vh ====
// offsets, field positions and reset values of the mac status register bank
`ifndef MAC_STATUS_DEFINES_VH
`define MAC_STATUS_DEFINES_VH

`define ADDR_W              4
`define OFS_STATUS          4'h0
`define OFS_IRQ_STATUS      4'h4
`define OFS_IRQ_ENABLE      4'h8
`define OFS_IRQ_CLEAR       4'hc

`define IDLE_BIT            31
`define TXCODE_HI           23
`define TXCODE_LO           20
`define TXCH_HI             18
`define TXCH_LO             16

`define ERR_NONE            4'h0
`define ERR_NO_SOP          4'h1
`define ERR_NO_OWNER        4'h2
`define ERR_NULL_NEXT       4'h3
`define ERR_NULL_BUF        4'h4
`define ERR_ZERO_LEN        4'h5
`define ERR_SHORT_PKT       4'h6

`define IRQ_W               2
`define IRQ_HOST_ERR        0
`define IRQ_CH_CLEARED      1
`define IRQ_RESET           2'h0

`endif

// ==== hdl/tx_error_capture.v ====
// latch of the first transmit host error code and channel
`timescale 1ns/1ps
`default_nettype none
`include "mac_status_defines.vh"

module tx_error_capture (
  input  wire       i_clk,
  input  wire       i_rst,
  input  wire       i_err_valid,
  input  wire [2:0] i_err_kind,
  input  wire [2:0] i_err_chan,
  input  wire       i_clear_chan,
  output wire [3:0] o_code,
  output wire [2:0] o_chan,
  output wire       o_pending,
  output wire       o_new_err
);

  reg  [3:0] code_r;
  reg  [2:0] chan_r;
  reg  [3:0] code_nxt;
  wire       take;

  // kind 1..6 map onto the error codes, anything else is ignored
  always @* begin
    case (i_err_kind)
      3'h1:    code_nxt = `ERR_NO_SOP;     // RL4
      3'h2:    code_nxt = `ERR_NO_OWNER;   // RL4
      3'h3:    code_nxt = `ERR_NULL_NEXT;  // RL4
      3'h4:    code_nxt = `ERR_NULL_BUF;   // RL5
      3'h5:    code_nxt = `ERR_ZERO_LEN;   // RL5
      3'h6:    code_nxt = `ERR_SHORT_PKT;  // RL5
      default: code_nxt = `ERR_NONE;       // RL6
    endcase
  end

  // only the first error is held until reset
  assign take = i_err_valid && (code_r == `ERR_NONE) && (code_nxt != `ERR_NONE); // RL7

  always @(posedge i_clk) begin
    if (i_rst) begin
      code_r <= `ERR_NONE;
      chan_r <= 3'h0;
    end else begin
      if (take) begin
        code_r <= code_nxt;  // RL3
      end
      if (take) begin
        chan_r <= i_err_chan;  // RL9
      end else if (i_clear_chan) begin
        chan_r <= 3'h0;  // RL10
      end
    end
  end

  assign o_code    = code_r;
  assign o_chan    = chan_r;
  assign o_pending = (code_r != `ERR_NONE);
  assign o_new_err = take;

endmodule // tx_error_capture

`default_nettype wire

// ==== hdl/tx_host_error_status.v ====
// mac status register bank: idle flag and transmit host error report
//
// Function
// RL1: idle reads 0 in reset, 1 after
// RL2: idle follows controller idle state
// RL3: 4-bit tx error code in bits 23:20
// RL4: codes 1h 2h 3h for descriptor errors
// RL5: codes 4h 5h 6h for buffer errors
// RL6: zero packet length reports no code
// RL7: error held until hardware reset
// RL8: software reads code after interrupt
// RL9: 3-bit tx error channel in 18:16
// RL10: status read clears channel field
// RL11: reserved bits zero, writes ignored
`timescale 1ns/1ps
`default_nettype none
`include "mac_status_defines.vh"

module tx_host_error_status (
  input  wire                 i_clk,
  input  wire                 i_rst,
  // avalon-mm slave
  input  wire [`ADDR_W-1:0]   i_avs_address,
  input  wire                 i_avs_read,
  input  wire                 i_avs_write,
  input  wire [31:0]          i_avs_writedata,
  input  wire [3:0]           i_avs_byteenable,
  output reg  [31:0]          o_avs_readdata,
  output wire                 o_avs_waitrequest,
  output wire [1:0]           o_avs_response,
  // controller state and dma error report
  input  wire                 i_ctrl_idle,
  input  wire                 i_err_valid,
  input  wire [2:0]           i_err_kind,
  input  wire [2:0]           i_err_chan,
  // host error state and interrupt
  output wire                 o_host_error_pending,
  output wire                 o_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // bus handshake: one wait cycle, answer on the second edge

  reg                 ack_r;
  wire                req;
  wire                rd_done;
  wire                wr_done;
  reg  [`IRQ_W-1:0]   irq_stat_r;
  reg  [`IRQ_W-1:0]   irq_en_r;
  reg                 idle_r;
  reg  [31:0]         rdata_nxt;
  reg                 bad_nxt;
  reg                 bad_r;
  wire [3:0]          tx_code;
  wire [2:0]          tx_chan;
  wire                new_err;
  wire                clear_chan;
  wire [`IRQ_W-1:0]   irq_set;
  wire [`IRQ_W-1:0]   irq_clr;

  assign req               = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = req & ~ack_r;
  assign rd_done           = i_avs_read & ack_r;
  assign wr_done           = i_avs_write & ack_r;
  assign o_avs_response    = bad_r ? 2'h3 : 2'h0;

  always @(posedge i_clk) begin
    if (i_rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // idle flag: zero in reset, follows the controller afterwards

  always @(posedge i_clk) begin
    if (i_rst) begin
      idle_r <= 1'b0;  // RL1
    end else begin
      idle_r <= i_ctrl_idle;  // RL2
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit error capture

  assign clear_chan = rd_done && (i_avs_address == `OFS_STATUS);  // RL10

  tx_error_capture u_capture (
    .i_clk        (i_clk),
    .i_rst        (i_rst),
    .i_err_valid  (i_err_valid),
    .i_err_kind   (i_err_kind),
    .i_err_chan   (i_err_chan),
    .i_clear_chan (clear_chan),
    .o_code       (tx_code),
    .o_chan       (tx_chan),
    .o_pending    (o_host_error_pending),
    .o_new_err    (new_err)
  );

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status, enable and clear; set wins over clear

  assign irq_set = {clear_chan & (tx_chan != 3'h0), new_err};
  assign irq_clr = (wr_done && (i_avs_address == `OFS_IRQ_CLEAR) && i_avs_byteenable[0]) ?
                   i_avs_writedata[`IRQ_W-1:0] : {`IRQ_W{1'b0}};

  genvar g;
  generate
    for (g = 0; g < `IRQ_W; g = g + 1) begin : g_irq
      always @(posedge i_clk) begin
        if (i_rst) begin
          irq_stat_r[g] <= 1'b0;
        end else if (irq_set[g]) begin
          irq_stat_r[g] <= 1'b1;
        end else if (irq_clr[g]) begin
          irq_stat_r[g] <= 1'b0;
        end
      end
    end
  endgenerate

  always @(posedge i_clk) begin
    if (i_rst) begin
      irq_en_r <= `IRQ_RESET;
    end else if (wr_done && (i_avs_address == `OFS_IRQ_ENABLE) && i_avs_byteenable[0]) begin
      irq_en_r <= i_avs_writedata[`IRQ_W-1:0];
    end
  end

  assign o_irq = |(irq_stat_r & irq_en_r);

  ////////////////////////////////////////////////////////////////////////////
  // read mux; writes to the status word are dropped

  always @* begin
    rdata_nxt = 32'h0000_0000;  // RL11
    bad_nxt   = 1'b0;
    case (i_avs_address)
      `OFS_STATUS: begin
        rdata_nxt[`IDLE_BIT]              = idle_r;   // RL1
        rdata_nxt[`TXCODE_HI:`TXCODE_LO]  = tx_code;  // RL3
        rdata_nxt[`TXCH_HI:`TXCH_LO]      = tx_chan;  // RL9
      end
      `OFS_IRQ_STATUS: begin
        rdata_nxt[`IRQ_W-1:0] = irq_stat_r;
      end
      `OFS_IRQ_ENABLE: begin
        rdata_nxt[`IRQ_W-1:0] = irq_en_r;
      end
      `OFS_IRQ_CLEAR: begin
        rdata_nxt = 32'h0000_0000;
      end
      default: begin
        bad_nxt = 1'b1;
      end
    endcase
  end

  always @(posedge i_clk) begin
    if (i_rst) begin
      o_avs_readdata <= 32'h0000_0000;
      bad_r          <= 1'b0;
    end else if (req & ~ack_r) begin
      o_avs_readdata <= i_avs_read ? rdata_nxt : 32'h0000_0000;
      bad_r          <= bad_nxt;
    end
  end

endmodule // tx_host_error_status

`default_nettype wire

// ==== testbench/tx_host_error_status_chk.sv ====
// assertions on the mac status register bank ports
`timescale 1ns/1ps
`default_nettype none
module tx_host_error_status_chk (
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic [3:0]  i_avs_address,
  input wire logic        i_avs_read,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  input wire logic        i_ctrl_idle,
  input wire logic        i_err_valid,
  input wire logic [2:0]  i_err_kind,
  input wire logic        o_host_error_pending
);
  wire  rd0 = i_avs_read & ~o_avs_waitrequest & (i_avs_address == 4'h0);
  logic seen_r;
  always @(posedge i_clk)
    seen_r <= i_rst ? 1'b0 : (seen_r | (rd0 & o_host_error_pending));
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  property p_rst_rd; $past(i_rst) |-> o_avs_readdata == 32'h0; endproperty
  a_rst_rd: assert property (p_rst_rd) else $error("readdata not 0 out of reset");
  property p_idle;
    rd0 && i_ctrl_idle == $past(i_ctrl_idle) && i_ctrl_idle == $past(i_ctrl_idle, 2)
      |-> o_avs_readdata[31] == i_ctrl_idle;
  endproperty
  a_idle: assert property (p_idle) else $error("idle bit wrong");
  property p_rsv; rd0 |-> o_avs_readdata[30:24] == 7'h0 && !o_avs_readdata[19]; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
  property p_nocode; rd0 && !o_host_error_pending |-> o_avs_readdata[23:20] == 4'h0; endproperty
  a_nocode: assert property (p_nocode) else $error("code without error");
  property p_raise;
    i_err_valid && i_err_kind != 3'h0 && i_err_kind != 3'h7 && !o_host_error_pending
      |-> ##[1:2] o_host_error_pending;
  endproperty
  a_raise: assert property (p_raise) else $error("error not raised");
  property p_zlen;
    i_err_valid && i_err_kind == 3'h0 && !o_host_error_pending |=> !o_host_error_pending [*2];
  endproperty
  a_zlen: assert property (p_zlen) else $error("zero length reported");
  property p_stick; $past(o_host_error_pending) |-> o_host_error_pending; endproperty
  a_stick: assert property (p_stick) else $error("error left without reset");
  property p_chclr; rd0 && seen_r |-> o_avs_readdata[18:16] == 3'h0; endproperty
  a_chclr: assert property (p_chclr) else $error("channel not cleared");
endmodule // tx_host_error_status_chk
bind tx_host_error_status tx_host_error_status_chk i_chk (.*);
`default_nettype wire

// ==== testbench/tx_host_error_status_tb_top.sv ====
// bench for the mac status register bank
`timescale 1ns/1ps
`default_nettype none
module tx_host_error_status_tb_top;
  logic        clk = 0, rst = 1, rd = 0, wr = 0, idle = 1, ev = 0;
  logic        wq, pend, irq;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wd = 32'h0, q, got;
  logic [2:0]  kind = 3'h0, chn = 3'h0;
  logic [1:0]  resp, rs;
  int          error_cnt = 0, tests_run = 0, cyc = 0;
  always #25 clk = ~clk;
  tx_host_error_status i_dut (.i_clk(clk), .i_rst(rst), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hf),
    .o_avs_readdata(q), .o_avs_waitrequest(wq), .o_avs_response(resp),
    .i_ctrl_idle(idle), .i_err_valid(ev), .i_err_kind(kind), .i_err_chan(chn),
    .o_host_error_pending(pend), .o_irq(irq));
  task automatic finish_test;
    $display("checks=%0d errors=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // one avalon transfer; request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    @(posedge clk);
    while (wq) @(posedge clk);
    got = q;
    rs = resp;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic err(input int k, input int c);
    @(posedge clk);
    ev <= 1'b1;
    kind <= 3'(k);
    chn <= 3'(c);
    @(posedge clk);
    ev <= 1'b0;
  endtask
  task automatic rst_dut;
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      finish_test;
    end
  end
  initial begin
    rst_dut;
    bus(0, 4'h0, 0);
    chk(got, 32'h8000_0000);
    bus(1, 4'h0, 32'hffff_ffff);
    bus(0, 4'h0, 0);
    chk(got, 32'h8000_0000);
    bus(0, 4'h2, 0);
    chk(rs, 32'h3);
    chk(got, 32'h0);
    idle <= 1'b0;
    bus(0, 4'h0, 0);
    chk(got, 32'h0);
    idle <= 1'b1;
    err(0, 5);
    err(7, 3);
    bus(0, 4'h0, 0);
    chk(got, 32'h8000_0000);
    chk(pend, 32'h0);
    for (int k = 1; k <= 6; k++) begin
      rst_dut;
      bus(1, 4'h8, k & 1);
      bus(0, 4'h8, 0);
      chk(got, k & 1);
      err(k, 8 - k);
      bus(0, 4'h0, 0);
      chk(got, 32'h8000_0000 | k << 20 | (8 - k) << 16);
      chk(irq, k & 1);
      err(k % 6 + 1, 0);
      bus(0, 4'h0, 0);
      chk(got, 32'h8000_0000 | k << 20);
      chk(pend, 32'h1);
      bus(0, 4'h4, 0);
      chk(got, 32'h3);
      bus(1, 4'hc, 3);
      bus(0, 4'h4, 0);
      chk(got, 32'h0);
      chk(irq, 32'h0);
    end
    rst_dut;
    bus(0, 4'h0, 0);
    chk(got, 32'h8000_0000);
    finish_test;
  end
endmodule // tx_host_error_status_tb_top
`default_nettype wire
